// ---- logic/nested_irq_ctrl.sv ----
// Overview of operation
// - Pick highest software level, then hardware order.
// - Unserved requests stay latched as pending.
// - Reset, trap, emergency stop rank above levels.
// - Non-maskable taken at any level; level forced to 3.
// - Of the non-maskable sources only trap leaves halt.
// - After reset run at level 3, top priority.
// - Maskable served if enabled and level higher.
// - Emergency stop from pin edge or speed error.
// - External edge latched, cleared on service entry.
// - Selected pins of one group ORed together.
// - Any enabled source ends wait; wake-capable ones end halt.
// - Peripheral request needs flag and enable set.
// - Clear sequence drops the pending peripheral latch.
// - After halt, wake-capable source is served first.
// - Lower vector number means higher hardware priority.
// - Level in bits 5 and 3, fixed encoding.
// - Entry loads level from the vector's pair.
// - Four priority bytes, reset FFh, top nibble ones.
// - Writing level-0 pattern keeps the old pair.
// - Stop pair ignored; top sources set both bits.
// - Raised pair during own routine re-enters it.
// - Instructions load 10 or 11; pops restore.
// - Core finishes instruction and stacks before vectoring.
// - Return pops saved level back.
`timescale 1ns/10ps
module nested_irq_ctrl
  import nested_irq_pkg::*;
#(
  parameter int EXT_WIDTH = 4
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 estopPin,
  input  wire logic                 speedError,
  input  wire logic [EXT_WIDTH-1:0] extGroup0,
  input  wire logic [EXT_WIDTH-1:0] extGroup1,
  input  wire logic [EXT_WIDTH-1:0] extGroup2,
  input  wire logic [13:0]          periphFlag,
  input  wire logic [13:0]          periphEnable,
  input  wire logic [13:0]          clearSeq,
  input  wire logic                 irqAck,
  input  wire logic                 instrEnable,
  input  wire logic                 instrDisable,
  input  wire logic                 instrHalt,
  input  wire logic                 instrWait,
  input  wire logic                 instrTrap,
  input  wire logic                 ccPopValid,
  input  wire logic [7:0]           ccPopData,
  output logic                      irqRequest,
  output logic      [3:0]           irqVector,
  output logic      [7:0]           condCodes,
  output logic                      inHalt,
  output logic                      inWait
);

  if (EXT_WIDTH < 1 || EXT_WIDTH > 8) begin : g_check
    $error("EXT_WIDTH must lie between 1 and 8");
  end

  // Rank of a level pair: level 0 lowest, level 3 highest.
  function automatic logic [1:0] levelRank(input logic [1:0] pair);
    unique case (pair)
      LEVEL_0: levelRank = 2'h0;
      LEVEL_1: levelRank = 2'h1;
      LEVEL_2: levelRank = 2'h2;
      LEVEL_3: levelRank = 2'h3;
    endcase
  endfunction

  // Per-pair write merge: a level-0 pattern leaves the stored pair alone.
  function automatic logic [7:0] mergePairs(input logic [7:0] old, input logic [7:0] wr);
    logic [7:0] res;
    res = wr;
    for (int p = 0; p < 4; p++) begin
      if (wr[2*p +: 2] == LEVEL_0) begin
        res[2*p +: 2] = old[2*p +: 2];
      end
    end
    return res;
  endfunction

  logic [27:0]  prio;
  logic [7:0]   ccReg;
  logic [13:0]  enableReg;
  logic [11:0]  extSel;
  logic         estopFalling;
  logic [13:0]  periphPend;
  logic [2:0]   extPend;
  logic [2:0]   extPrev;
  logic         estopPend;
  logic         estopPrev;
  logic         trapPend;
  logic         resetSvc;
  logic         haltFirst;
  power_mode_t  powerMode;
  logic         dpWrite;
  logic [7:0]   dpAddr;

  // Bus decode; the slave never inserts wait states, so the address phase is one cycle.
  wire        addrPhase = hsel & htrans[1] & hready;
  wire [7:0]  aAddr     = haddr[7:0];
  wire        wrPrio0   = dpWrite & (dpAddr == OFF_PRIO0);
  wire        wrPrio1   = dpWrite & (dpAddr == OFF_PRIO1);
  wire        wrPrio2   = dpWrite & (dpAddr == OFF_PRIO2);
  wire        wrPrio3   = dpWrite & (dpAddr == OFF_PRIO3);
  wire        wrEnable  = dpWrite & (dpAddr == OFF_ENABLE);
  wire        wrExtSel  = dpWrite & (dpAddr == OFF_EXTSEL);
  wire        wrConfig  = dpWrite & (dpAddr == OFF_CONFIG);
  wire [7:0]  prio3Read = {PRIO3_TOP, prio[27:24]};
  wire [1:0]  curLevel  = {ccReg[CC_LEVEL_HIGH], ccReg[CC_LEVEL_LOW]};
  wire [1:0]  curRank   = levelRank(curLevel);

  // Source request terms.
  wire [13:0] periphReq = periphFlag & periphEnable & PERIPH_MASK;
  wire [2:0]  extLevel  = {|(extGroup2 & extSel[11:8]),
                           |(extGroup1 & extSel[7:4]),
                           |(extGroup0 & extSel[3:0])};
  wire [2:0]  extRise   = extLevel & ~extPrev;
  wire        estopEdge = estopFalling ? (estopPrev & ~estopPin) : (~estopPrev & estopPin);
  wire        estopSet  = estopEdge | speedError;
  wire [13:0] pendAll   = (periphPend & PERIPH_MASK)
                        | {9'h000, extPend, 2'h0}
                        | {13'h0000, estopPend};
  wire [13:0] pendEn    = pendAll & enableReg;

  // Low-power wake terms: any enabled source ends wait, only capable ones end halt.
  wire        waitWake  = (|pendEn) | trapPend;
  wire        haltWake  = (|(pendEn & HALT_WAKE_MASK)) | trapPend;
  wire        takeNow   = irqAck & irqRequest;

  // Arbitration: emergency stop ranks above every level; ties fall to the lower vector number.
  logic [3:0] bestVec;
  logic [2:0] bestScore;
  logic       bestFound;
  always_comb begin
    bestVec   = VEC_ESTOP;
    bestScore = 3'h0;
    bestFound = 1'b0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      logic [2:0] score;
      logic       elig;
      score = (i == 0) ? 3'h4 : {1'b0, levelRank(prio[2*i +: 2])};
      elig  = pendEn[i] & ((i == 0) | (score[1:0] > curRank))
            & (~haltFirst | HALT_WAKE_MASK[i]);
      if (elig && (!bestFound || score >= bestScore)) begin
        bestVec   = 4'(i);
        bestScore = score;
        bestFound = 1'b1;
      end
    end
  end

  // Reset outranks trap, which outranks the stop and all maskable vectors.
  wire [3:0] next_irqVector  = resetSvc ? VEC_RESET : (trapPend ? VEC_TRAP : bestVec);
  wire       next_irqRequest = (powerMode == PM_RUN) & (resetSvc | trapPend | bestFound);

  // Level loaded on entry: top sources force level 3, maskable ones take their pair.
  // Trap and reset have no stored pair, so they are steered to vector 0 to keep the select in range.
  wire       topVec     = (irqVector == VEC_ESTOP) || (irqVector >= VEC_TRAP);
  wire [3:0] pairVec    = topVec ? VEC_ESTOP : irqVector;
  wire [1:0] entryLevel = topVec ? LEVEL_3 : prio[{pairVec, 1'b0} +: 2];
  wire       ackExt     = takeNow && (irqVector >= 4'(EXT_FIRST_VEC))
                          && (irqVector < 4'(EXT_FIRST_VEC + EXT_GROUPS));
  wire [2:0] extClr     = ackExt ? (3'h1 << (irqVector - 4'(EXT_FIRST_VEC))) : 3'h0;

  // Read mux; unmapped addresses read as zero.
  logic [31:0] readMux;
  always_comb begin
    unique case (aAddr)
      OFF_PRIO0:  readMux = {24'h000000, prio[7:0]};
      OFF_PRIO1:  readMux = {24'h000000, prio[15:8]};
      OFF_PRIO2:  readMux = {24'h000000, prio[23:16]};
      OFF_PRIO3:  readMux = {24'h000000, prio3Read};
      OFF_CCODES: readMux = {24'h000000, ccReg};
      OFF_ENABLE: readMux = {18'h00000, enableReg};
      OFF_EXTSEL: readMux = {20'h00000, extSel};
      OFF_CONFIG: readMux = {31'h00000000, estopFalling};
      OFF_STATUS: readMux = {7'h00, powerMode, irqRequest, irqVector,
                             trapPend, resetSvc, 2'h0, pendAll};
      default:    readMux = 32'h00000000;
    endcase
  end

  // Bus slave: zero-wait, always OKAY; writes land in the data phase.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dpWrite   <= 1'b0;
      dpAddr    <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dpWrite   <= addrPhase & hwrite;
      dpAddr    <= aAddr;
      hrdata    <= (addrPhase && !hwrite) ? readMux : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Priority pairs; the emergency-stop pair is stored but never consulted.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio <= {PRIO_RESET[3:0], PRIO_RESET, PRIO_RESET, PRIO_RESET};
    end else begin
      if (wrPrio0) prio[7:0]   <= mergePairs(prio[7:0], hwdata[7:0]);
      if (wrPrio1) prio[15:8]  <= mergePairs(prio[15:8], hwdata[7:0]);
      if (wrPrio2) prio[23:16] <= mergePairs(prio[23:16], hwdata[7:0]);
      if (wrPrio3) prio[27:24] <= 4'(mergePairs(prio3Read, hwdata[7:0]));
    end
  end

  // Block control: source enables, external pin selects, stop edge polarity.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enableReg    <= ENABLE_RESET;
      extSel       <= EXTSEL_RESET;
      estopFalling <= 1'b0;
    end else begin
      if (wrEnable) enableReg    <= hwdata[13:0];
      if (wrExtSel) extSel       <= hwdata[11:0];
      if (wrConfig) estopFalling <= hwdata[0];
    end
  end

  // Level bits: entry beats a pop, a pop beats the level instructions.
  // The core only acks at an instruction boundary after stacking, so no push logic lives here.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ccReg <= CC_RESET;
    end else if (takeNow) begin
      ccReg[CC_LEVEL_HIGH] <= entryLevel[1];
      ccReg[CC_LEVEL_LOW]  <= entryLevel[0];
    end else if (ccPopValid) begin
      ccReg <= ccPopData;
    end else if (instrEnable || instrHalt || instrWait) begin
      ccReg[CC_LEVEL_HIGH] <= LEVEL_0[1];
      ccReg[CC_LEVEL_LOW]  <= LEVEL_0[0];
    end else if (instrDisable || instrTrap) begin
      ccReg[CC_LEVEL_HIGH] <= LEVEL_3[1];
      ccReg[CC_LEVEL_LOW]  <= LEVEL_3[0];
    end
  end

  // Pending latches: a new event wins over its own clear, except the
  // peripheral clear sequence, which discards the latch outright.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      periphPend <= 14'h0000;
      extPend    <= 3'h0;
      extPrev    <= 3'h0;
      estopPend  <= 1'b0;
      estopPrev  <= 1'b0;
      trapPend   <= 1'b0;
      resetSvc   <= 1'b1;
    end else begin
      periphPend <= (periphPend | periphReq) & ~clearSeq;
      extPend    <= (extPend & ~extClr) | extRise;
      extPrev    <= extLevel;
      estopPend  <= (estopPend & ~(takeNow && irqVector == VEC_ESTOP)) | estopSet;
      estopPrev  <= estopPin;
      trapPend   <= (trapPend & ~(takeNow && irqVector == VEC_TRAP)) | instrTrap;
      resetSvc   <= resetSvc & ~(takeNow && irqVector == VEC_RESET);
    end
  end

  // Power modes; the first service after halt is limited to wake-capable sources.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerMode <= PM_RUN;
      haltFirst <= 1'b0;
    end else begin
      unique case (powerMode)
        PM_RUN: begin
          if (instrHalt) powerMode <= PM_HALT;
          else if (instrWait) powerMode <= PM_WAIT;
          if (takeNow) haltFirst <= 1'b0;
        end
        PM_WAIT: begin
          if (waitWake) powerMode <= PM_RUN;
        end
        PM_HALT: begin
          if (haltWake) begin
            powerMode <= PM_RUN;
            haltFirst <= ~trapPend;
          end
        end
        default: powerMode <= PM_RUN;
      endcase
    end
  end

  // Registered arbitration result and mode flags toward the core.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqRequest <= 1'b0;
      irqVector  <= 4'h0;
      inHalt     <= 1'b0;
      inWait     <= 1'b0;
    end else begin
      irqRequest <= next_irqRequest & ~takeNow;
      irqVector  <= next_irqVector;
      inHalt     <= (powerMode == PM_HALT);
      inWait     <= (powerMode == PM_WAIT);
    end
  end

  assign condCodes = ccReg;

  // Checks on the arbitration and level handling.
  a_trap_over_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
    (trapPend && powerMode == PM_RUN && !takeNow) |=> irqRequest && irqVector >= VEC_TRAP)
    else $error("Pending trap not presented ahead of maskable sources");

  a_entry_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    (takeNow && !topVec) |=> curLevel == $past(entryLevel))
    else $error("Entry level not loaded from priority pair");

  a_nmi_level3: assert property (@(posedge core_clk) disable iff (!rst_n)
    (takeNow && topVec) |=> curLevel == LEVEL_3)
    else $error("Top source entry did not force level 3");

  a_level3_masks: assert property (@(posedge core_clk) disable iff (!rst_n)
    (curLevel == LEVEL_3 && !resetSvc && !trapPend && !pendEn[0]) |=> !irqRequest)
    else $error("Maskable request presented at level 3");

  a_no_level0: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrPrio0 |=> prio[7:0] != 8'hAA && (prio[1:0] != LEVEL_0))
    else $error("Level-0 pattern stored in a priority pair");

  a_ext_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (takeNow && irqVector == 4'h2 && !extRise[0]) |=> !extPend[0])
    else $error("External latch not cleared on entry");

  a_periph_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|clearSeq) |=> (periphPend & $past(clearSeq)) == 14'h0000)
    else $error("Clear sequence did not drop pending latch");

  a_halt_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    (powerMode == PM_HALT && haltWake) |=> powerMode == PM_RUN ##1 inHalt == 1'b0)
    else $error("Halt not left on wake-capable request");

  a_halt_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    (irqRequest && $past(haltFirst) && irqVector <= VEC_LAST_MASK)
      |-> HALT_WAKE_MASK[irqVector])
    else $error("Non-wake source served first after halt");

  a_disable_lvl: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instrDisable && !takeNow && !ccPopValid && !instrEnable && !instrHalt && !instrWait)
      |=> curLevel == LEVEL_3)
    else $error("Disable instruction did not set level 3");

  c_nested_entry: cover property (@(posedge core_clk) disable iff (!rst_n)
    takeNow && !topVec ##[1:20] takeNow && !topVec);

  c_halt_exit: cover property (@(posedge core_clk) disable iff (!rst_n)
    powerMode == PM_HALT ##1 powerMode == PM_RUN ##[1:10] takeNow);

  c_estop_taken: cover property (@(posedge core_clk) disable iff (!rst_n)
    takeNow && irqVector == VEC_ESTOP);

endmodule // nested_irq_ctrl

// ---- pkg/nested_irq_pkg.sv ----
package nested_irq_pkg;

  // Vector numbering: 0 is the emergency stop, 1 to 13 are maskable sources.
  localparam int         NUM_VEC        = 14;
  localparam logic [3:0] VEC_ESTOP      = 4'h0;
  localparam logic [3:0] VEC_LAST_MASK  = 4'hD;
  localparam logic [3:0] VEC_TRAP       = 4'hE;
  localparam logic [3:0] VEC_RESET      = 4'hF;
  localparam int         EXT_FIRST_VEC  = 2;
  localparam int         EXT_GROUPS     = 3;

  // Source classes and halt-wake capability, one bit per vector.
  localparam logic [13:0] HALT_WAKE_MASK = 14'h111E;
  localparam logic [13:0] PERIPH_MASK    = 14'h3FE2;
  localparam logic [13:0] EXT_MASK       = 14'h001C;

  // Level-bit encodings, written as {high, low}.
  localparam logic [1:0] LEVEL_0 = 2'h2;
  localparam logic [1:0] LEVEL_1 = 2'h1;
  localparam logic [1:0] LEVEL_2 = 2'h0;
  localparam logic [1:0] LEVEL_3 = 2'h3;

  // Condition-code layout and reset value.
  localparam int         CC_LEVEL_HIGH = 5;
  localparam int         CC_LEVEL_LOW  = 3;
  localparam logic [7:0] CC_RESET      = 8'hEA;

  // Priority register reset and the read-only top nibble of the last one.
  localparam logic [7:0] PRIO_RESET    = 8'hFF;
  localparam logic [3:0] PRIO3_TOP     = 4'hF;

  // Byte addresses on the register bus.
  localparam logic [7:0] OFF_PRIO0     = 8'h00;
  localparam logic [7:0] OFF_PRIO1     = 8'h04;
  localparam logic [7:0] OFF_PRIO2     = 8'h08;
  localparam logic [7:0] OFF_PRIO3     = 8'h0C;
  localparam logic [7:0] OFF_CCODES    = 8'h10;
  localparam logic [7:0] OFF_ENABLE    = 8'h14;
  localparam logic [7:0] OFF_EXTSEL    = 8'h18;
  localparam logic [7:0] OFF_CONFIG    = 8'h1C;
  localparam logic [7:0] OFF_STATUS    = 8'h20;

  // Reset values of the block's own control registers.
  localparam logic [13:0] ENABLE_RESET = 14'h0000;
  localparam logic [11:0] EXTSEL_RESET = 12'h000;

  typedef enum logic [1:0] {
    PM_RUN  = 2'b00,
    PM_WAIT = 2'b01,
    PM_HALT = 2'b10
  } power_mode_t;

endpackage

// ---- testbench/core_model.sv ----
`timescale 1ns/10ps
module core_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       irqRequest,
  input  wire logic [3:0] irqVector,
  input  wire logic [1:0] ackDelay,
  output logic            irqAck,
  output logic      [3:0] lastVec,
  output logic      [7:0] ackCount
);
  logic [1:0] waitCnt;

  // The core spends ackDelay cycles finishing and stacking before it takes the vector.
  // The vector is recorded only at the edge where the acknowledge is really sampled.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqAck   <= 1'b0;
      lastVec  <= 4'h0;
      ackCount <= 8'h00;
      waitCnt  <= 2'h0;
    end else if (irqAck) begin
      irqAck  <= 1'b0;
      waitCnt <= 2'h0;
      if (irqRequest) begin
        lastVec  <= irqVector;
        ackCount <= ackCount + 8'h01;
      end
    end else if (irqRequest && waitCnt == ackDelay) begin
      irqAck <= 1'b1;
    end else if (irqRequest) begin
      waitCnt <= waitCnt + 2'h1;
    end else begin
      waitCnt <= 2'h0;
    end
  end
endmodule // core_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import nested_irq_pkg::*;
;
  localparam logic [5:0] OP_ENA = 6'h01, OP_DIS = 6'h02, OP_HALT = 6'h04;
  localparam logic [5:0] OP_WAIT = 6'h08, OP_TRAP = 6'h10, OP_POP = 6'h20;

  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdS;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0, hreadyout, hresp, irqAck, irqRequest, inHalt, inWait;
  logic        estopPin = 1'b0, speedError = 1'b0;
  logic [3:0]  extGroup0 = 4'h0, extGroup1 = 4'h0, irqVector, lastVec;
  logic [27:0] srcs = 28'h0;
  logic [13:0] periphEnable = 14'h3FBF;
  logic [5:0]  ops = 6'h0;
  logic [7:0]  condCodes, ackCount;
  logic [1:0]  ackDelay = 2'h0;
  logic [1:0]  curLevel;
  int          n_fail = 0, n_checks = 0;

  // Level bits pulled out of the condition-code byte.
  assign curLevel = {condCodes[CC_LEVEL_HIGH], condCodes[CC_LEVEL_LOW]};

  // Clock and a sampler that keeps read data as it stood before each edge.
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) rdS <= hrdata;

  nested_irq_ctrl #(.EXT_WIDTH(4)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .estopPin(estopPin), .speedError(speedError),
    .extGroup0(extGroup0), .extGroup1(extGroup1), .extGroup2(4'h0),
    .periphFlag(srcs[13:0]), .periphEnable(periphEnable), .clearSeq(srcs[27:14]),
    .irqAck(irqAck), .instrEnable(ops[0]), .instrDisable(ops[1]), .instrHalt(ops[2]),
    .instrWait(ops[3]), .instrTrap(ops[4]), .ccPopValid(ops[5]), .ccPopData(8'hE2),
    .irqRequest(irqRequest), .irqVector(irqVector), .condCodes(condCodes),
    .inHalt(inHalt), .inWait(inWait)
  );

  core_model core (
    .core_clk(core_clk), .rst_n(rst_n), .irqRequest(irqRequest), .irqVector(irqVector),
    .ackDelay(ackDelay), .irqAck(irqAck), .lastVec(lastVec), .ackCount(ackCount)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Single word transfers; the address phase is held until ready is seen high.
  task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    #1;
    chk(rdS, exp);
  endtask

  // One-cycle pulses of the instruction strobes and of the flag and clear lines.
  task automatic op(input logic [5:0] m);
    @(posedge core_clk);
    ops <= m;
    @(posedge core_clk);
    ops <= 6'h0;
  endtask

  task automatic pulse(input logic [27:0] m);
    @(posedge core_clk);
    srcs <= m;
    @(posedge core_clk);
    srcs <= 28'h0;
  endtask

  task automatic lvl_is(input logic [1:0] l);
    #1;
    chk({30'h0, curLevel}, {30'h0, l});
  endtask

  // Waits a bounded time for the core to take one vector, then checks it and the level.
  task automatic expect_ack(input logic [3:0] v, input logic [1:0] l);
    logic [7:0] c0;
    int         k;
    c0 = ackCount;
    k = 0;
    while (ackCount === c0 && k < 40) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk({24'h0, ackCount}, {24'h0, c0 + 8'h01});
    chk({28'h0, lastVec}, {28'h0, v});
    lvl_is(l);
  endtask

  task automatic no_ack;
    logic [7:0] c0;
    c0 = ackCount;
    repeat (8) @(posedge core_clk);
    #1;
    chk({24'h0, ackCount}, {24'h0, c0});
  endtask

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    expect_ack(VEC_RESET, LEVEL_3);
    for (int i = 0; i < 4; i++) begin
      rd_chk(OFF_PRIO0 + 8'(4 * i), {24'h0, PRIO_RESET});
    end
    rd_chk(OFF_CCODES, {24'h0, CC_RESET});
    rd_chk(8'h3C, 32'h0);
    ahb_write(OFF_PRIO1, 32'hCF);
    ahb_write(OFF_PRIO1, 32'h64);
    rd_chk(OFF_PRIO1, 32'h44);
    ahb_write(OFF_PRIO3, 32'h0);
    rd_chk(OFF_PRIO3, 32'hF0);
    ahb_write(OFF_PRIO2, 32'hF3);
    ahb_write(OFF_ENABLE, 32'h3FFF);
    op(OP_ENA);
    lvl_is(LEVEL_0);
    pulse(28'h40);
    no_ack();
    pulse(28'h2A0);
    expect_ack(4'h9, LEVEL_2);
    pulse(28'h1 << 23);
    op(OP_POP);
    expect_ack(4'h5, LEVEL_1);
    no_ack();
    pulse(28'h1 << 19);
    op(OP_POP);
    expect_ack(4'h7, LEVEL_1);
    pulse(28'h1 << 21);
    op(OP_DIS);
    pulse(28'h400);
    pulse(28'h1 << 24);
    op(OP_ENA);
    no_ack();
    ackDelay <= 2'h3;
    op(OP_DIS);
    op(OP_TRAP);
    expect_ack(VEC_TRAP, LEVEL_3);
    ackDelay <= 2'h0;
    op(OP_ENA);
    estopPin <= 1'b1;
    expect_ack(VEC_ESTOP, LEVEL_3);
    @(posedge core_clk);
    speedError <= 1'b1;
    @(posedge core_clk);
    speedError <= 1'b0;
    expect_ack(VEC_ESTOP, LEVEL_3);
    op(OP_ENA);
    ahb_write(OFF_EXTSEL, 32'h13);
    extGroup0 <= 4'h4;
    no_ack();
    extGroup0 <= 4'h6;
    expect_ack(4'h2, LEVEL_3);
    op(OP_POP);
    no_ack();
    ahb_write(OFF_PRIO0, 32'h7F);
    ahb_write(OFF_PRIO1, 32'h40);
    op(OP_HALT);
    pulse(28'h20);
    no_ack();
    chk({31'h0, inHalt}, 32'h1);
    extGroup1 <= 4'h1;
    expect_ack(4'h3, LEVEL_1);
    expect_ack(4'h5, LEVEL_2);
    chk({31'h0, inHalt}, 32'h0);
    pulse(28'h1 << 19);
    op(OP_POP);
    op(OP_HALT);
    op(OP_TRAP);
    expect_ack(VEC_TRAP, LEVEL_3);
    op(OP_WAIT);
    lvl_is(LEVEL_0);
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0, inWait}, 32'h1);
    pulse(28'h200);
    expect_ack(4'h9, LEVEL_2);
    ahb_write(OFF_PRIO2, 32'hFF);
    expect_ack(4'h9, LEVEL_3);
    final_report();
  end
endmodule // tb_top
